// ==== logic/pin_defines.svh ====
// timing, field positions and reset levels for the serial and modem pin logic
`ifndef PIN_DEFINES_SVH
`define PIN_DEFINES_SVH
`define MODEM_CTRL_DTR_BIT 0
`define MODEM_CTRL_RTS_BIT 1
`define MODEM_CTRL_OP2_BIT 3
`define MODEM_CTRL_IR_BIT 6
`define FEAT_CTRL_IRINV_BIT 2
`define FEAT_CTRL_RS485_BIT 3
`define ENH_FEAT_ARTS_BIT 6
`define ENH_FEAT_ACTS_BIT 7
`define INT_EN_CTSINT_BIT 7
`define ENH_MODE_485Q_BIT 3
`define IR_PULSE_NS 16
`define CLK_NS 4
`define IR_PULSE_CYC ((`IR_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define MODEM_CTRL_RST 8'h00
`endif

// ==== logic/pin_pkg.sv ====
// types for the serial and modem pin logic
package pin_pkg;
  typedef struct packed {
    logic [7:0] modem_control_reg;
    logic [7:0] feature_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] enhanced_mode_select_reg;
  } chan_ctrl_t;
  typedef struct packed {
    logic tx_valid;
    logic tx_data;
    logic int_req;
    logic rx_has_data;
    logic rts_flow_n;
  } chan_core_t;
  typedef enum logic [2:0] {
    IR_IDLE = 3'b001,
    IR_PULSE = 3'b010,
    IR_REST = 3'b100
  } ir_state_t;
endpackage : pin_pkg

// ==== logic/pin_chan.sv ====
// one channel of serial, modem and status pin logic
`timescale 1ns/10ps
`default_nettype none
`include "pin_defines.svh"
module pin_chan (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pin_pkg::chan_ctrl_t ctrl,
  input wire pin_pkg::chan_core_t core,
  input wire logic serial_in,
  input wire logic clear_to_send_n,
  output logic serial_out_r,
  output logic request_to_send_n_r,
  output logic terminal_ready_n_r,
  output logic general_output_two_n_r,
  output logic irq_out_r,
  output logic irq_oe_n_r,
  output logic receiver_ready_n_r,
  output logic rx_bit_r,
  output logic tx_allowed_r,
  output logic cts_event_r
);
  import pin_pkg::*;
  logic ir_mode;
  logic [3:0] cnt_r;
  logic ir_tx_r;
  logic cts_d_r;
  logic rx_in;
  ir_state_t st_r;
  assign ir_mode = ctrl.modem_control_reg[`MODEM_CTRL_IR_BIT];
  // infrared receive idles low; optional inversion before the decoder
  assign rx_in = ir_mode ? (serial_in ^ ctrl.feature_control_reg[`FEAT_CTRL_IRINV_BIT]) :
    serial_in;
  // infrared encoder: a short high pulse for each zero bit, low otherwise
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= IR_IDLE;
      cnt_r <= 4'h0;
      ir_tx_r <= 1'b0;
    end else begin
      unique case (st_r)
        IR_IDLE: begin
          ir_tx_r <= 1'b0;
          if (core.tx_valid && !core.tx_data) begin
            st_r <= IR_PULSE;
            ir_tx_r <= 1'b1;
            cnt_r <= 4'(`IR_PULSE_CYC);
          end
        end
        IR_PULSE: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            st_r <= IR_REST;
            ir_tx_r <= 1'b0;
          end
        end
        IR_REST: begin
          if (!core.tx_valid) st_r <= IR_IDLE;
        end
      endcase
    end
  end
  // line output: high idle in standard mode, low idle in infrared mode
  always_ff @(posedge mclk) begin
    if (!rst_n) serial_out_r <= 1'b1;
    else if (ir_mode) serial_out_r <= ir_tx_r;
    else serial_out_r <= core.tx_valid ? core.tx_data : 1'b1;
  end
  // decoded receive bit; standard mode passes the line level through
  always_ff @(posedge mclk) begin
    if (!rst_n) rx_bit_r <= 1'b1;
    else rx_bit_r <= ir_mode ? ~rx_in : rx_in;
  end
  // op2 pin and interrupt enable; op2 is the inverse of the control bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      general_output_two_n_r <= 1'b1;
      irq_oe_n_r <= 1'b1;
      irq_out_r <= 1'b0;
    end else begin
      general_output_two_n_r <= ~ctrl.modem_control_reg[`MODEM_CTRL_OP2_BIT];
      irq_oe_n_r <= ~ctrl.modem_control_reg[`MODEM_CTRL_OP2_BIT];
      irq_out_r <= core.int_req;
    end
  end
  // rts: manual bit, auto flow or rs485 direction (asserted while sending with the 485q bit clear, inverted with it set)
  always_ff @(posedge mclk) begin
    if (!rst_n) request_to_send_n_r <= 1'b1;
    else if (ctrl.feature_control_reg[`FEAT_CTRL_RS485_BIT])
      request_to_send_n_r <= ~(core.tx_valid ^
        ctrl.enhanced_mode_select_reg[`ENH_MODE_485Q_BIT]);
    else if (ctrl.enhanced_feature_reg[`ENH_FEAT_ARTS_BIT])
      // relies on software having asserted the manual bit first
      request_to_send_n_r <= ~ctrl.modem_control_reg[`MODEM_CTRL_RTS_BIT] |
        core.rts_flow_n;
    else request_to_send_n_r <= ~ctrl.modem_control_reg[`MODEM_CTRL_RTS_BIT];
  end
  // dtr is a plain general output, active low
  always_ff @(posedge mclk) begin
    if (!rst_n) terminal_ready_n_r <= 1'b1;
    else terminal_ready_n_r <= ~ctrl.modem_control_reg[`MODEM_CTRL_DTR_BIT];
  end
  // auto cts gating and its change event; dsr/cd/ri are never looked at
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_allowed_r <= 1'b1;
      cts_d_r <= 1'b1;
      cts_event_r <= 1'b0;
    end else begin
      cts_d_r <= clear_to_send_n;
      tx_allowed_r <= !ctrl.enhanced_feature_reg[`ENH_FEAT_ACTS_BIT] ||
        !clear_to_send_n;
      cts_event_r <= ctrl.enhanced_feature_reg[`ENH_FEAT_ACTS_BIT] &&
        ctrl.interrupt_enable_reg[`INT_EN_CTSINT_BIT] && (cts_d_r != clear_to_send_n);
    end
  end
  // receiver ready, low while receive data waits
  always_ff @(posedge mclk) begin
    if (!rst_n) receiver_ready_n_r <= 1'b1;
    else receiver_ready_n_r <= ~core.rx_has_data;
  end
  idle_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !ir_mode && !core.tx_valid |=> serial_out_r || $past(ir_mode))
    else $error("standard idle not high");
  op2_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(ctrl.modem_control_reg[`MODEM_CTRL_OP2_BIT]) |->
      !general_output_two_n_r && !irq_oe_n_r)
    else $error("op2 set not reflected");
  op2_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(ctrl.modem_control_reg[`MODEM_CTRL_OP2_BIT]) |->
      general_output_two_n_r && irq_oe_n_r)
    else $error("op2 clear not reflected");
  rxrdy_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    core.rx_has_data |=> !receiver_ready_n_r)
    else $error("receiver ready not low");
  cts_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl.enhanced_feature_reg[`ENH_FEAT_ACTS_BIT] && clear_to_send_n |=> !tx_allowed_r)
    else $error("cts gate open");
  ir_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ir_mode && st_r == IR_IDLE ##1 ir_mode |=> !serial_out_r || ir_tx_r)
    else $error("ir idle not low");
  ir_cover_c: cover property (@(posedge mclk) st_r == IR_PULSE);
  cts_cover_c: cover property (@(posedge mclk) cts_event_r);
  op2_cover_c: cover property (@(posedge mclk) !general_output_two_n_r);
endmodule : pin_chan
`default_nettype wire

// ==== logic/pin_top.sv ====
// Operation
// - standard mode: transmit idles and resets high
// - infrared mode: encoder path, transmit idles low
// - infrared receive idles low, optional inversion
// - op2 bit set: interrupt active, op2 low
// - op2 bit clear: interrupt tristate, op2 high
// - dsr, cd, ri have no effect
// - auto cts flow control with interrupt enable
// - rts as auto rs485 direction control
// - receiver ready output shows receive status
// - dtr is active-low general output
`timescale 1ns/10ps
`default_nettype none
module pin_top (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // per channel controls and core status, index 0 = a, 1 = b
  input wire pin_pkg::chan_ctrl_t CTRL [2],
  input wire pin_pkg::chan_core_t CORE [2],
  // line inputs; the remote end keeps standard receive idle high
  input wire logic [1:0] SERIAL_IN,
  input wire logic [1:0] CLEAR_TO_SEND_N,
  input wire logic [1:0] SET_READY_N,
  input wire logic [1:0] CARRIER_DETECT_N,
  input wire logic [1:0] RING_INDICATOR_N,
  // line and status outputs
  output logic [1:0] SERIAL_OUT,
  output logic [1:0] REQUEST_TO_SEND_N,
  output logic [1:0] TERMINAL_READY_N,
  output logic [1:0] GENERAL_OUTPUT_TWO_N,
  output logic [1:0] IRQ_OUT,
  output logic [1:0] IRQ_OE_N,
  output logic [1:0] RECEIVER_READY_N,
  // back to the channel core
  output logic [1:0] RX_BIT,
  output logic [1:0] TX_ALLOWED,
  output logic [1:0] CTS_EVENT,
  output logic [5:0] GP_IN
);
  import pin_pkg::*;
  // general inputs only reported, never steer the channel
  always_ff @(posedge MCLK) begin
    if (!RST_N) GP_IN <= 6'h3f;
    else GP_IN <= {SET_READY_N, CARRIER_DETECT_N, RING_INDICATOR_N};
  end
  // two independent copies, each with its own controls
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      pin_chan u_chan (
        .mclk(MCLK),
        .rst_n(RST_N),
        .ctrl(CTRL[g]),
        .core(CORE[g]),
        .serial_in(SERIAL_IN[g]),
        .clear_to_send_n(CLEAR_TO_SEND_N[g]),
        .serial_out_r(SERIAL_OUT[g]),
        .request_to_send_n_r(REQUEST_TO_SEND_N[g]),
        .terminal_ready_n_r(TERMINAL_READY_N[g]),
        .general_output_two_n_r(GENERAL_OUTPUT_TWO_N[g]),
        .irq_out_r(IRQ_OUT[g]),
        .irq_oe_n_r(IRQ_OE_N[g]),
        .receiver_ready_n_r(RECEIVER_READY_N[g]),
        .rx_bit_r(RX_BIT[g]),
        .tx_allowed_r(TX_ALLOWED[g]),
        .cts_event_r(CTS_EVENT[g])
      );
    end
  endgenerate
endmodule : pin_top
`default_nettype wire

// ==== test/line_end.sv ====
// remote line end model driving each channel's receive wire
`timescale 1ns/10ps
`default_nettype none
module line_end (
  // clock
  input wire logic clk,
  // per channel mode and bit to send
  input wire logic [1:0] ir_mode,
  input wire logic [1:0] sending,
  input wire logic [1:0] bit_val,
  // receive wires into the device
  output logic [1:0] line
);
  initial line = 2'b11;
  // idle high in standard mode, low in infrared; never leaves the wire floating
  always @(posedge clk) begin
    line <= (sending & bit_val) | (~sending & ~ir_mode);
  end
endmodule : line_end
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the serial and modem pin logic
`timescale 1ns/10ps
`default_nettype none
`include "pin_defines.svh"
module testbench;
  import pin_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  chan_ctrl_t ctrl [2];
  chan_core_t core [2];
  logic [1:0] ir = 2'b00, snd = 2'b00, bv = 2'b00, cts_n = 2'b11, gp = 2'b11, sin;
  logic [1:0] sout, rts_n, dtr_n, op2_n, irq, oe_n, rdy_n, rxb, txok, ctsev;
  logic [5:0] gpin;
  logic [7:0] k;
  int n_errors = 0;
  int samples_checked = 0;
  line_end far (.clk(mclk), .ir_mode(ir), .sending(snd), .bit_val(bv), .line(sin));
  pin_top dut (.MCLK(mclk), .RST_N(rst_n), .CTRL(ctrl), .CORE(core), .SERIAL_IN(sin),
    .CLEAR_TO_SEND_N(cts_n), .SET_READY_N(gp), .CARRIER_DETECT_N(gp),
    .RING_INDICATOR_N(gp), .SERIAL_OUT(sout), .REQUEST_TO_SEND_N(rts_n),
    .TERMINAL_READY_N(dtr_n), .GENERAL_OUTPUT_TWO_N(op2_n), .IRQ_OUT(irq),
    .IRQ_OE_N(oe_n), .RECEIVER_READY_N(rdy_n), .RX_BIT(rxb), .TX_ALLOWED(txok),
    .CTS_EVENT(ctsev), .GP_IN(gpin));
  initial forever #2 mclk = ~mclk;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // outputs are registered; three edges leave margin for the decoder stage
  task automatic lat();
    repeat (3) @(posedge mclk);
    #1;
  endtask : lat
  // bounded count of high cycles, so a stuck pulse cannot hang the run
  task automatic count(input int sel, output logic [7:0] n);
    n = 8'h00;
    repeat (12) begin
      @(posedge mclk);
      #1;
      n = n + ((sel == 0) ? ctsev[0] : sout[1]);
    end
  endtask : count
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    ctrl = '{default: '0};
    core = '{default: '0};
    // reset sampled low at three edges, released at the third by nba
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // core fields: tx_valid, tx_data, int_req, rx_has_data, rts_flow_n
    ctrl[0].modem_control_reg <= 8'h09;
    core[0] <= 5'b10111;
    #1;
    cmp({sout, op2_n, oe_n, rdy_n}, 8'hff);
    lat();
    cmp(sout, 2'b10);
    cmp({op2_n, oe_n, irq}, 6'b101001);
    cmp({dtr_n, rdy_n}, 4'b1010);
    @(posedge mclk);
    core[0] <= 5'b00001;
    gp <= 2'b00;
    snd[0] <= 1'b1;
    lat();
    cmp({gpin, sout}, 8'h03);
    cmp(rxb, 2'b10);
    @(posedge mclk);
    snd[0] <= 1'b0;
    ctrl[0].modem_control_reg[1] <= 1'b1;
    lat();
    cmp(rts_n[0], 1'b0);
    @(posedge mclk);
    ctrl[0].enhanced_feature_reg <= 8'hc0;
    ctrl[0].interrupt_enable_reg <= 8'h80;
    lat();
    cmp({rts_n[0], txok[0]}, 2'b10);
    @(posedge mclk);
    core[0] <= 5'b00000;
    cts_n[0] <= 1'b0;
    count(0, k);
    cmp(k, 8'h01);
    cmp({rts_n[0], txok[0]}, 2'b01);
    // rs485 direction on channel b while sending, then inverted by the 485q bit
    @(posedge mclk);
    ctrl[1].feature_control_reg <= 8'h08;
    core[1] <= 5'b11001;
    lat();
    cmp(rts_n[1], 1'b0);
    @(posedge mclk);
    ctrl[1].enhanced_mode_select_reg <= 8'h08;
    lat();
    cmp(rts_n[1], 1'b1);
    @(posedge mclk);
    ctrl[1] <= '{modem_control_reg: 8'h40, default: '0};
    core[1] <= 5'b00001;
    ir[1] <= 1'b1;
    lat();
    cmp({sout[1], rxb[1]}, 2'b01);
    @(posedge mclk);
    ctrl[1].feature_control_reg <= 8'h04;
    lat();
    cmp(rxb[1], 1'b0);
    @(posedge mclk);
    core[1] <= 5'b10001;
    count(1, k);
    cmp(k, 8'(`IR_PULSE_CYC));
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
